// ### tpc_field_model.sv
// field side model: digital inputs and a counting encoder
// assumes bench commands synchronous to core_clk
`timescale 1ns/1ns
module tpc_field_model (
    // clock, reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // bench commands
    input  wire logic [7:0]  digSet,
    input  wire logic [7:0]  extSet,
    input  wire logic        encRun,
    // field lines
    output logic [7:0]       digIn,
    output logic [7:0]       extEnIn,
    output logic [31:0]      encPos
);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            digIn   <= 8'h00;
            extEnIn <= 8'h00;
            encPos  <= 32'h0;
        end else begin
            digIn   <= digSet;
            extEnIn <= extSet;
            encPos  <= encPos + {31'h0, encRun};
        end
    end
endmodule

// ### tpc_pkg.sv
// constants shared by the trigger pulse channel block
// assumes a 10 MHz core clock and a 32-bit AXI4-Lite register master
// Notes on behaviour
// - eight independent channels, indexed zero to seven
// - each channel ties one chosen source to one chosen target output
// - sources are digital inputs, encoder compare, and every target output
// - two-bit unit field picks time or encoder units for delay and width
// - condition zero is the reset value and silences the channel
// - condition codes: 1 rising, 2 falling, 3 level, 4 continuous
// - option bits: 1 active low, 2 buffer, 4 gate starts off, 8 on
// - active low drives high during delay and low during width
// - outputs update once per tick; time lengths count whole ticks
// - tick period defaults to 25 us and is programmable
// - signed fine adjust moves the period by 0.0125 us per step
// - the combined period is never range checked by hardware
// - two software inputs as sources and two readable software outputs
// - encoder width is displacement from active to inactive edge
// - encoder source fires at the programmed encoder position
package tpc_pkg;
    localparam int NUM_CH       = 8;
    localparam int NUM_TGT      = 10;
    localparam int NUM_SRC      = 21;
    localparam int CLK_PERIOD_PS = 100000;
    localparam int FINE_STEP_PS  = 12500;
    localparam int STEPS_PER_US  = 1000000 / FINE_STEP_PS;
    localparam int STEPS_PER_CLK = CLK_PERIOD_PS / FINE_STEP_PS;
    localparam logic [15:0] TICK_US_DEF = 16'h0019;
    localparam int TICK_US_MIN = 25;
    localparam int TICK_US_MAX = 2500;
    // register byte offsets
    localparam logic [7:0] REG_TICK_US  = 8'h00;
    localparam logic [7:0] REG_FINE_ADJ = 8'h04;
    localparam logic [7:0] REG_SW_IN    = 8'h08;
    localparam logic [7:0] REG_OUT_STAT = 8'h0c;
    localparam logic [7:0] REG_BUSY     = 8'h10;
    localparam logic [7:0] REG_ENC_POS  = 8'h14;
    localparam logic [7:0] REG_CH_BASE  = 8'h40;
    localparam logic [7:0] REG_CH_END   = 8'hc0;
    localparam logic [1:0] CH_CFG   = 2'h0;
    localparam logic [1:0] CH_DELAY = 2'h1;
    localparam logic [1:0] CH_WIDTH = 2'h2;
    localparam logic [1:0] CH_FIRE  = 2'h3;
    // channel config field positions
    localparam int CFG_COND_LSB = 0;
    localparam int CFG_UNIT_LSB = 4;
    localparam int CFG_OPT_LSB  = 8;
    localparam int CFG_SRC_LSB  = 16;
    localparam int CFG_TGT_LSB  = 24;
    // trigger_condition codes
    localparam logic [2:0] TRIGGER_OFF        = 3'h0;
    localparam logic [2:0] TRIGGER_ON_RISE    = 3'h1;
    localparam logic [2:0] TRIGGER_ON_FALL    = 3'h2;
    localparam logic [2:0] TRIGGER_ON_LEVEL   = 3'h3;
    localparam logic [2:0] TRIGGER_CONTINUOUS = 3'h4;
    // pulse_unit_select: bit 1 delay in encoder units, bit 0 width
    localparam logic [1:0] TIME_DELAY_TIME_WIDTH         = 2'h0;
    localparam logic [1:0] TIME_DELAY_POSITION_WIDTH     = 2'h1;
    localparam logic [1:0] POSITION_DELAY_TIME_WIDTH     = 2'h2;
    localparam logic [1:0] POSITION_DELAY_POSITION_WIDTH = 2'h3;
    // channel_option_bits positions
    localparam int ACTIVE_LOW_FLAG          = 0;
    localparam int TRIGGER_BUFFER_FLAG      = 1;
    localparam int EXT_ENABLE_INITIALLY_OFF = 2;
    localparam int EXT_ENABLE_INITIALLY_ON  = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### tpc_trigger.sv
// eight-channel trigger pulse generator with an AXI4-Lite register slave
// assumes digital, encoder and enable inputs synchronous to core_clk
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module tpc_trigger
    import tpc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // field side
    input  wire logic [7:0]  digIn,
    input  wire logic [7:0]  extEnIn,
    input  wire logic [31:0] encPos,
    output logic [7:0]       trigOut,
    output logic [1:0]       swOut
);
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_DELAY = 3'b010,
        PH_WIDTH = 3'b100
    } tpc_phase_t;

    typedef struct packed {
        logic                      awReady;
        logic                      wReady;
        logic                      awHave;
        logic                      wHave;
        logic [7:0]                awAddr;
        logic [31:0]               wData;
        logic [3:0]                wStrb;
        logic                      bValid;
        logic [1:0]                bResp;
        logic                      arReady;
        logic                      rValid;
        logic [1:0]                rResp;
        logic [31:0]               rData;
        logic [15:0]               tickUs;
        logic [15:0]               fineAdj;
        logic [1:0]                swIn;
        logic [24:0]               tickAcc;
        logic                      tick;
        logic [NUM_CH-1:0][31:0]   cfg;
        logic [NUM_CH-1:0][31:0]   dly;
        logic [NUM_CH-1:0][31:0]   wid;
        logic [NUM_CH-1:0][31:0]   fire;
        logic [NUM_CH-1:0][31:0]   cnt;
        logic [NUM_CH-1:0][31:0]   start;
        tpc_phase_t [NUM_CH-1:0]   phase;
        logic [NUM_CH-1:0]         srcPrev;
        logic [NUM_CH-1:0]         pend;
        logic [NUM_CH-1:0]         gate;
        logic [NUM_CH-1:0]         extPrev;
        logic [NUM_TGT-1:0]        outs;
    } tpc_state_t;

    localparam tpc_state_t S_RST = '{
        awReady: 1'b1, wReady: 1'b1, arReady: 1'b1,
        tickUs:  TICK_US_DEF,
        phase:   '{default: PH_IDLE},
        default: '0
    };
    localparam logic [24:0] STEPS_US  = 25'(STEPS_PER_US);
    localparam logic [24:0] STEPS_CLK = 25'(STEPS_PER_CLK);

    tpc_state_t s_q;
    tpc_state_t s_d;

    logic [NUM_CH-1:0] srcLvl;
    logic [NUM_CH-1:0] evt;
    logic [NUM_CH-1:0] dlyDone;
    logic [NUM_CH-1:0] widDone;
    logic [NUM_CH-1:0] bufOn;
    logic [NUM_CH-1:0] gateOn;
    logic [NUM_CH-1:0] chBusy;
    logic signed [24:0] tickTotal;
    logic               wrNow;

    assign wrNow = s_q.awHave && s_q.wHave && !s_q.bValid;
    // combined period in fine steps, no range check
    assign tickTotal = signed'(s_q.tickUs * STEPS_US)
                     + 25'(signed'(s_q.fineAdj));

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gCh
            logic [2:0]         cond;
            logic [1:0]         unitSel;
            logic [3:0]         opt;
            logic [4:0]         srcSel;
            logic [NUM_SRC-1:0] srcVec;
            logic [31:0]        tEl;
            logic [31:0]        pEl;
            logic               gateOk;
            assign cond    = s_q.cfg[g][CFG_COND_LSB+:3];
            assign unitSel = s_q.cfg[g][CFG_UNIT_LSB+:2];
            assign opt     = s_q.cfg[g][CFG_OPT_LSB+:4];
            assign srcSel  = s_q.cfg[g][CFG_SRC_LSB+:5];
            // encoder compare, software inputs, targets, digital
            assign srcVec  = {encPos >= s_q.fire[g], s_q.swIn,
                              s_q.outs, digIn};
            assign srcLvl[g] = (srcSel < 5'(NUM_SRC)) ?
                               srcVec[srcSel] : 1'b0;
            // buffering outranks the enable gate options
            assign bufOn[g]  = opt[TRIGGER_BUFFER_FLAG];
            assign gateOn[g] = !bufOn[g] &&
                               (opt[EXT_ENABLE_INITIALLY_OFF] ||
                                opt[EXT_ENABLE_INITIALLY_ON]);
            assign gateOk = !gateOn[g] || s_q.gate[g];
            always_comb begin
                case (cond)
                    TRIGGER_ON_RISE:    evt[g] = srcLvl[g] && !s_q.srcPrev[g];
                    TRIGGER_ON_FALL:    evt[g] = !srcLvl[g] && s_q.srcPrev[g];
                    TRIGGER_ON_LEVEL:   evt[g] = srcLvl[g];
                    TRIGGER_CONTINUOUS: evt[g] = 1'b1;
                    default:            evt[g] = 1'b0;
                endcase
                evt[g] = evt[g] && gateOk;
            end
            assign tEl = s_q.cnt[g] + 32'h1;
            assign pEl = encPos - s_q.start[g];
            assign dlyDone[g] = (unitSel[1] ? pEl : tEl) >= s_q.dly[g];
            assign widDone[g] = (unitSel[0] ? pEl : tEl) >= s_q.wid[g];
            assign chBusy[g] = s_q.phase[g] != PH_IDLE;

            modeOff_a: assert property (@(posedge core_clk)
                disable iff (rst || !clkEn)
                cond == TRIGGER_OFF && s_q.tick |=> s_q.phase[g] == PH_IDLE
            ) else $error("silenced channel left idle");
            riseStart_a: assert property (@(posedge core_clk)
                disable iff (rst || !clkEn)
                s_q.tick && !wrNow && cond == TRIGGER_ON_RISE && gateOk &&
                s_q.phase[g] == PH_IDLE && srcLvl[g] && !s_q.srcPrev[g]
                |=> s_q.phase[g] == PH_DELAY && s_q.cnt[g] == 32'h0
            ) else $error("rising edge did not start a pulse");
            widthAfter_a: assert property (@(posedge core_clk)
                disable iff (rst || !clkEn)
                s_q.tick && !wrNow && cond != TRIGGER_OFF &&
                s_q.phase[g] == PH_DELAY && dlyDone[g]
                |=> s_q.phase[g] == PH_WIDTH
            ) else $error("width did not follow delay");
            alwaysLoop_a: assert property (@(posedge core_clk)
                disable iff (rst || !clkEn)
                s_q.tick && !wrNow && cond == TRIGGER_CONTINUOUS &&
                s_q.phase[g] == PH_WIDTH && widDone[g]
                |=> s_q.phase[g] == PH_DELAY
            ) else $error("continuous train stopped");
            delayCount_a: assert property (@(posedge core_clk)
                disable iff (rst || !clkEn)
                s_q.tick && !wrNow && !unitSel[1] &&
                cond != TRIGGER_OFF && s_q.phase[g] == PH_DELAY &&
                !dlyDone[g]
                |=> s_q.phase[g] == PH_DELAY &&
                    s_q.cnt[g] == $past(s_q.cnt[g]) + 32'h1
            ) else $error("delay tick count wrong");
        end
    endgenerate

    always_comb begin
        logic [3:0]  chOff;
        logic [2:0]  ch;
        logic [31:0] mask;
        logic [31:0] rd;
        logic        hit;
        logic        lvl;
        logic [24:0] nxt;
        s_d    = s_q;
        chOff  = 4'h0;
        ch     = 3'h0;
        mask   = 32'h0;
        rd     = 32'h0;
        hit    = 1'b0;
        lvl    = 1'b0;
        nxt    = s_q.tickAcc + STEPS_CLK;
        // fractional accumulator gives 0.0125 us resolution on 100 ns
        s_d.tick = 1'b0;
        if (signed'(nxt) >= tickTotal) begin
            s_d.tick    = 1'b1;
            s_d.tickAcc = (tickTotal > signed'(STEPS_CLK)) ?
                          nxt - tickTotal : 25'h0;
        end else begin
            s_d.tickAcc = nxt;
        end
        for (int c = 0; c < NUM_CH; c++) begin
            s_d.extPrev[c] = extEnIn[c];
            if (extEnIn[c] && !s_q.extPrev[c]) begin
                s_d.gate[c] = !s_q.gate[c];
            end
            if (s_q.tick) begin
                s_d.srcPrev[c] = srcLvl[c];
                if (s_q.cfg[c][CFG_COND_LSB+:3] == TRIGGER_OFF) begin
                    s_d.phase[c] = PH_IDLE;
                    s_d.pend[c]  = 1'b0;
                end else begin
                    case (s_q.phase[c])
                        PH_IDLE: begin
                            if (evt[c]) begin
                                s_d.phase[c] = PH_DELAY;
                                s_d.cnt[c]   = 32'h0;
                                s_d.start[c] = encPos;
                            end
                        end
                        PH_DELAY: begin
                            if (dlyDone[c]) begin
                                s_d.phase[c] = PH_WIDTH;
                                s_d.cnt[c]   = 32'h0;
                                s_d.start[c] = encPos;
                            end else begin
                                s_d.cnt[c] = s_q.cnt[c] + 32'h1;
                            end
                        end
                        PH_WIDTH: begin
                            if (!widDone[c]) begin
                                s_d.cnt[c] = s_q.cnt[c] + 32'h1;
                            end else if (s_q.pend[c] ||
                                s_q.cfg[c][CFG_COND_LSB+:3] ==
                                TRIGGER_CONTINUOUS) begin
                                s_d.phase[c] = PH_DELAY;
                                s_d.cnt[c]   = 32'h0;
                                s_d.start[c] = encPos;
                                s_d.pend[c]  = 1'b0;
                            end else begin
                                s_d.phase[c] = PH_IDLE;
                            end
                        end
                        default: begin
                            s_d.phase[c] = PH_IDLE;
                        end
                    endcase
                    // buffered event during a pulse is kept; set beats clear
                    if (chBusy[c] && evt[c] && bufOn[c]) begin
                        s_d.pend[c] = 1'b1;
                    end
                end
            end
        end
        // axi4-lite write channel, address and data in either order
        if (s_q.awReady && s_axi_awvalid) begin
            s_d.awHave  = 1'b1;
            s_d.awAddr  = s_axi_awaddr;
            s_d.awReady = 1'b0;
        end
        if (s_q.wReady && s_axi_wvalid) begin
            s_d.wHave  = 1'b1;
            s_d.wData  = s_axi_wdata;
            s_d.wStrb  = s_axi_wstrb;
            s_d.wReady = 1'b0;
        end
        if (s_q.bValid && s_axi_bready) begin
            s_d.bValid  = 1'b0;
            s_d.awReady = 1'b1;
            s_d.wReady  = 1'b1;
        end
        if (wrNow) begin
            mask = {{8{s_q.wStrb[3]}}, {8{s_q.wStrb[2]}},
                    {8{s_q.wStrb[1]}}, {8{s_q.wStrb[0]}}};
            chOff = s_q.awAddr[7:4] - REG_CH_BASE[7:4];
            ch    = chOff[2:0];
            hit   = 1'b1;
            s_d.awHave = 1'b0;
            s_d.wHave  = 1'b0;
            s_d.bValid = 1'b1;
            if (s_q.awAddr >= REG_CH_BASE && s_q.awAddr < REG_CH_END &&
                s_q.awAddr[1:0] == 2'h0) begin
                case (s_q.awAddr[3:2])
                    CH_CFG: begin
                        s_d.cfg[ch] = (s_q.cfg[ch] & ~mask) |
                                      (s_q.wData & mask);
                        s_d.phase[ch] = PH_IDLE;
                        s_d.pend[ch]  = 1'b0;
                        s_d.cnt[ch]   = 32'h0;
                        s_d.gate[ch]  = !s_d.cfg[ch][CFG_OPT_LSB +
                                        EXT_ENABLE_INITIALLY_OFF];
                    end
                    CH_DELAY: s_d.dly[ch]  = (s_q.dly[ch] & ~mask) |
                                             (s_q.wData & mask);
                    CH_WIDTH: s_d.wid[ch]  = (s_q.wid[ch] & ~mask) |
                                             (s_q.wData & mask);
                    default:  s_d.fire[ch] = (s_q.fire[ch] & ~mask) |
                                             (s_q.wData & mask);
                endcase
            end else begin
                case (s_q.awAddr)
                    REG_TICK_US:  s_d.tickUs = (s_q.tickUs & ~mask[15:0]) |
                                               (s_q.wData[15:0] & mask[15:0]);
                    REG_FINE_ADJ: s_d.fineAdj = (s_q.fineAdj & ~mask[15:0]) |
                                                (s_q.wData[15:0] & mask[15:0]);
                    REG_SW_IN: begin
                        if (s_q.wStrb[0]) begin
                            s_d.swIn = s_q.wData[1:0];
                        end
                    end
                    default: hit = 1'b0;
                endcase
            end
            s_d.bResp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        // axi4-lite read channel
        if (s_q.rValid && s_axi_rready) begin
            s_d.rValid  = 1'b0;
            s_d.arReady = 1'b1;
        end
        if (s_q.arReady && s_axi_arvalid) begin
            chOff = s_axi_araddr[7:4] - REG_CH_BASE[7:4];
            ch    = chOff[2:0];
            hit   = 1'b1;
            if (s_axi_araddr >= REG_CH_BASE && s_axi_araddr < REG_CH_END &&
                s_axi_araddr[1:0] == 2'h0) begin
                case (s_axi_araddr[3:2])
                    CH_CFG:   rd = s_q.cfg[ch];
                    CH_DELAY: rd = s_q.dly[ch];
                    CH_WIDTH: rd = s_q.wid[ch];
                    default:  rd = s_q.fire[ch];
                endcase
            end else begin
                case (s_axi_araddr)
                    REG_TICK_US:  rd = {16'h0, s_q.tickUs};
                    REG_FINE_ADJ: rd = {16'h0, s_q.fineAdj};
                    REG_SW_IN:    rd = {30'h0, s_q.swIn};
                    REG_OUT_STAT: rd = {22'h0, s_q.outs};
                    REG_BUSY:     rd = {8'h0, s_q.pend, s_q.gate, chBusy};
                    REG_ENC_POS:  rd = encPos;
                    default:      hit = 1'b0;
                endcase
            end
            s_d.rData   = rd;
            s_d.rResp   = hit ? RESP_OKAY : RESP_SLVERR;
            s_d.rValid  = 1'b1;
            s_d.arReady = 1'b0;
        end
        // targets follow the new phase; lowest channel wins a clash
        if (s_q.tick) begin
            for (int t = 0; t < NUM_TGT; t++) begin
                s_d.outs[t] = 1'b0;
                for (int c = NUM_CH - 1; c >= 0; c--) begin
                    lvl = (s_d.phase[c] == PH_WIDTH) ^
                          s_d.cfg[c][CFG_OPT_LSB + ACTIVE_LOW_FLAG];
                    if (s_d.cfg[c][CFG_TGT_LSB+:4] == 4'(t) &&
                        s_d.cfg[c][CFG_COND_LSB+:3] != TRIGGER_OFF) begin
                        s_d.outs[t] = lvl;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= S_RST;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awReady;
    assign s_axi_wready  = s_q.wReady;
    assign s_axi_bvalid  = s_q.bValid;
    assign s_axi_bresp   = s_q.bResp;
    assign s_axi_arready = s_q.arReady;
    assign s_axi_rvalid  = s_q.rValid;
    assign s_axi_rresp   = s_q.rResp;
    assign s_axi_rdata   = s_q.rData;
    assign trigOut       = s_q.outs[7:0];
    assign swOut         = s_q.outs[9:8];

    holdTick_a: assert property (@(posedge core_clk)
        disable iff (rst || !clkEn)
        !s_q.tick |=> s_q.outs == $past(s_q.outs)
    ) else $error("target moved between ticks");
    tickGap_a: assert property (@(posedge core_clk)
        disable iff (rst || !clkEn)
        s_q.tick && tickTotal >= 25'sd72 && s_q.tickAcc < 25'd8
        |=> !s_q.tick [*8]
    ) else $error("tick period too short");
    activeLow_a: assert property (@(posedge core_clk)
        disable iff (rst || !clkEn)
        s_q.tick && s_d.cfg[1][CFG_TGT_LSB+:4] == 4'h1 &&
        s_d.cfg[0][CFG_TGT_LSB+:4] != 4'h1 &&
        s_d.cfg[1][CFG_OPT_LSB + ACTIVE_LOW_FLAG] &&
        s_d.cfg[1][CFG_COND_LSB+:3] != TRIGGER_OFF
        |=> trigOut[1] == (s_q.phase[1] != PH_WIDTH)
    ) else $error("active low level wrong");

    trainSeen_c: cover property (@(posedge core_clk) disable iff (rst)
        s_q.phase[0] == PH_WIDTH ##1 s_q.phase[0] == PH_DELAY);
    pendSeen_c: cover property (@(posedge core_clk) disable iff (rst)
        s_q.pend != '0);
    lowSeen_c: cover property (@(posedge core_clk) disable iff (rst)
        $fell(trigOut[0]));
    writeSeen_c: cover property (@(posedge core_clk) disable iff (rst)
        s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
endmodule

// ### trigger_pulse_channels_test.sv
// bench for the trigger block: register tasks and pulse timing checks
// assumes the field model drives the inputs
`timescale 1ns/1ns
module trigger_pulse_channels_test;
    import tpc_pkg::*;
    logic        core_clk = 1'b0, rst = 1'b1, encRun = 1'b0;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic        arValid = 1'b0, rReady = 1'b0;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00, digSet = 8'h02;
    logic [7:0]  extSet = 8'h00;
    logic [31:0] wData = 32'h0, rData, encPos;
    logic        awRdy, wRdy, bValid, arRdy, rValid;
    logic [1:0]  bResp, rResp, swOut;
    logic [7:0]  digIn, extEnIn, trigOut;
    logic [9:0]  outs;
    int          fails = 0, testsRun = 0;
    assign outs = {swOut, trigOut};
    always #50 core_clk = ~core_clk;
    tpc_field_model fld_u (.core_clk(core_clk), .rst(rst), .digSet(digSet),
        .extSet(extSet), .encRun(encRun), .digIn(digIn),
        .extEnIn(extEnIn), .encPos(encPos));
    tpc_trigger dut_u (.core_clk(core_clk), .rst(rst), .clkEn(1'b1),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .digIn(digIn),
        .extEnIn(extEnIn), .encPos(encPos), .trigOut(trigOut),
        .swOut(swOut));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bit aw = 0, w = 0;
        @(posedge core_clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aw && w)) begin
            @(posedge core_clk);
            if (awRdy) awValid <= 1'b0;
            if (wRdy) wValid <= 1'b0;
            aw |= awRdy;
            w |= wRdy;
        end
        do @(posedge core_clk); while (!bValid);
        bReady <= 1'b0;
        chk({30'h0, bResp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] er);
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arRdy) arValid <= 1'b0;
        end while (!rValid);
        rReady <= 1'b0;
        chk(rData & m, e);
        chk({30'h0, rResp}, {30'h0, er});
    endtask
    // delay 2 ticks, width 3 ticks, then the channel word
    task automatic cfg(input logic [3:0] c, input logic [31:0] w);
        wr(REG_CH_BASE + {c, 4'h4}, 32'h2, RESP_OKAY);
        wr(REG_CH_BASE + {c, 4'h8}, 32'h3, RESP_OKAY);
        wr(REG_CH_BASE + {c, 4'h0}, w, RESP_OKAY);
    endtask
    // waits for level lv on output b, then counts cycles it stays
    task automatic plen(input int b, input logic lv, input int e);
        int k = 0;
        while (outs[b] !== lv) @(posedge core_clk);
        while (outs[b] === lv && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        chk(32'(k), 32'(e));
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rd(REG_TICK_US, 32'hffff, 32'h19, RESP_OKAY);
        rd(REG_FINE_ADJ, 32'hffff, 32'h0, RESP_OKAY);
        wr(8'h30, 32'h1, RESP_SLVERR);
        rd(8'h30, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(REG_TICK_US, 32'h1, RESP_OKAY);
        cfg(4'h0, 32'h0000_0001);
        cfg(4'h1, 32'h0101_0102);
        cfg(4'h4, 32'h0300_0000);
        digSet <= 8'h03;
        plen(0, 1'b1, 30);
        digSet <= 8'h08;
        plen(1, 1'b0, 30);
        cfg(4'h2, 32'h0200_0004);
        plen(2, 1'b1, 30);
        plen(2, 1'b0, 20);
        cfg(4'h3, 32'h0812_0003);
        wr(REG_SW_IN, 32'h1, RESP_OKAY);
        while (swOut[0] !== 1'b1) @(posedge core_clk);
        rd(REG_OUT_STAT, 32'h100, 32'h100, RESP_OKAY);
        // fire position 50 goes first to 8'h9c, the fire register of channel 5, before channel 5 is set
        wr(REG_CH_BASE + 8'h5c, 32'd50, RESP_OKAY);
        cfg(4'h5, 32'h0414_0001);
        encRun <= 1'b1;
        repeat (40) @(posedge core_clk);
        chk({31'h0, trigOut[4]}, 32'h0);
        plen(4, 1'b1, 30);
        rd(REG_OUT_STAT, 32'h8, 32'h0, RESP_OKAY);
        wr(REG_FINE_ADJ, 32'h0000fff8, RESP_OKAY);
        cfg(4'h2, 32'h0200_0004);
        plen(2, 1'b1, 27);
        // buffered level source restarts straight after the width
        cfg(4'h7, 32'h0512_0203);
        plen(5, 1'b1, 27);
        plen(5, 1'b0, 18);
        // width of 20 encoder counts at one count per cycle: 3 ticks
        cfg(4'h6, 32'h0913_0011);
        wr(8'ha8, 32'd20, RESP_OKAY);
        wr(REG_SW_IN, 32'h3, RESP_OKAY);
        plen(9, 1'b1, 27);
        // gate starts off: no pulse until the enable line rises
        cfg(4'h0, 32'h0012_0403);
        repeat (40) @(posedge core_clk);
        chk({31'h0, trigOut[0]}, 32'h0);
        extSet <= 8'h01;
        plen(0, 1'b1, 27);
        end_of_test();
    end
endmodule
